// *** common/atcfg_pkg.sv ***
package atcfg_pkg;
   // command codes presented by the upstream text parser
   typedef enum logic [3:0] {
      CMD_ATTENTION,
      CMD_RESET,
      CMD_FACTORY,
      CMD_SECURITY_SET,
      CMD_PIN_SET,
      CMD_NAME_SET,
      CMD_LOW_POWER_SET,
      CMD_CONNECT,
      CMD_FIRMWARE_UPDATE,
      CMD_SETTINGS_DUMP,
      CMD_SETTING_READ,
      CMD_SETTING_WRITE,
      CMD_PENDING_ABORT,
      CMD_ESCAPE,
      CMD_RETURN_ONLINE,
      CMD_SIGNAL_STRENGTH
   } atcfg_cmd_type;

   // link status
   typedef enum logic [1:0] {
      LINK_STANDBY,
      LINK_PENDING,
      LINK_CONNECT
   } atcfg_link_type;

   // answer kinds
   typedef enum logic [2:0] {
      RSP_NONE,
      RSP_OK,
      RSP_ERROR,
      RSP_VALUE,
      RSP_DUMP_PAIR,
      RSP_GARBAGE
   } atcfg_rsp_type;

   // apb register byte offsets
   localparam logic [7:0] OFS_CMD = 8'h00;
   localparam logic [7:0] OFS_ARG = 8'h04;
   localparam logic [7:0] OFS_RSP = 8'h08;
   localparam logic [7:0] OFS_CFG = 8'h0c;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
   localparam logic [7:0] OFS_NAME_LEN = 8'h1c;

   // setting register file
   localparam int SETTING_COUNT = 47;
   localparam int SETTING_AW = 6;
   localparam logic [5:0] IDX_LOW_POWER = 6'h06;
   localparam logic [5:0] IDX_RESPONSE_ENABLE = 6'h0a;
   localparam logic [7:0] RESPONSE_ENABLE_RESET = 8'h01;
   localparam logic [7:0] LOW_POWER_RESET = 8'h00;
   localparam int NAME_MAX = 30;

   // field positions
   localparam int ARG_IDX_LSB = 8;
   localparam int ARG_AUTH_BIT = 0;
   localparam int ARG_ENCR_BIT = 1;
   localparam int ST_AUTH_BIT = 0;
   localparam int ST_ENCR_BIT = 1;
   localparam int ST_DFU_BIT = 2;
   localparam int ST_LPM_BIT = 3;
   localparam int ST_BUSY_BIT = 4;
   localparam int IRQ_RSP_BIT = 0;
   localparam int IRQ_ERR_BIT = 1;
   localparam logic [7:0] GARBAGE_BYTE = 8'ha5;

   // low power wake-up time
   localparam int WAKE_MS = 2000;
   localparam int CLK_MHZ = 200;
   localparam longint WAKE_CYCLES = longint'(WAKE_MS) * 1000 * CLK_MHZ;
endpackage

// *** hdl/atcfg_sticky.sv ***
`timescale 1ns/1ps
// sticky flag: set wins over clear
module atcfg_sticky (
   input wire logic clk,
   input wire logic srst,
   input wire logic set,
   input wire logic clr,
   output logic q
);
   logic q_reg;
   logic q_next;
   always_comb begin
      q_next = q_reg;
      if (clr) begin
         q_next = 1'b0;
      end
      if (set) begin
         q_next = 1'b1;
      end
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         q_reg <= 1'b0;
      end else begin
         q_reg <= q_next;
      end
   end
   assign q = q_reg;
endmodule

// *** hdl/atcfg_interp.sv ***
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/1ps
module atcfg_interp #(
   parameter longint WAKE_CYC = atcfg_pkg::WAKE_CYCLES,
   parameter logic [46:0] PROTECT_MASK = 47'h0000_0000_0000
) (
   input wire logic REF_CLK,
   input wire logic SRST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic [1:0] LINK_STATUS,
   input wire logic DATA_ACTIVE,
   output logic LOW_POWER,
   output logic IRQ
);
   // the dump walker needs one index past the last setting
   if (WAKE_CYC < 1 || atcfg_pkg::SETTING_COUNT >= (1 << atcfg_pkg::SETTING_AW)) begin : g_bad_param
      $error("wake count or setting count out of range");
   end

   // ======================================================
   // apb slave
   logic [31:0] prdata_reg, prdata_next;
   logic pready_reg, pready_next;
   logic pslverr_reg, pslverr_next;
   logic [31:0] arg_reg, arg_next;
   logic [4:0] name_len_reg, name_len_next;
   logic [3:0] mask_reg, mask_next;
   logic cmd_go;
   logic stat_rd;
   logic [1:0] link_s1_reg, link_s2_reg;
   logic act_s1_reg, act_s2_reg;
   logic [3:0] cmd_code;
   logic [31:0] status_word;
   logic [3:0] irq_flags;
   logic [7:0] rsp_data_reg, rsp_data_next;
   logic [2:0] rsp_kind_reg, rsp_kind_next;
   logic rsp_valid_reg, rsp_valid_next;

   wire apb_acc = PSEL && PENABLE && !pready_reg;

   always_comb begin
      prdata_next = prdata_reg;
      pready_next = 1'b0;
      pslverr_next = 1'b0;
      arg_next = arg_reg;
      mask_next = mask_reg;
      cmd_go = 1'b0;
      cmd_code = PWDATA[3:0];
      stat_rd = 1'b0;
      if (apb_acc) begin
         pready_next = 1'b1;
         prdata_next = 32'h0000_0000;
         if (PWRITE) begin
            if (PADDR == atcfg_pkg::OFS_CMD) begin
               cmd_go = 1'b1;
            end else if (PADDR == atcfg_pkg::OFS_ARG) begin
               arg_next = PWDATA;
            end else if (PADDR == atcfg_pkg::OFS_IRQ_MASK) begin
               mask_next = PWDATA[3:0];
            end else if (PADDR != atcfg_pkg::OFS_CFG) begin
               pslverr_next = 1'b1;
            end
         end else begin
            if (PADDR == atcfg_pkg::OFS_ARG) begin
               prdata_next = arg_reg;
            end else if (PADDR == atcfg_pkg::OFS_RSP) begin
               prdata_next = {20'h00000, rsp_valid_reg, rsp_kind_reg, rsp_data_reg};
            end else if (PADDR == atcfg_pkg::OFS_STATUS) begin
               prdata_next = status_word;
            end else if (PADDR == atcfg_pkg::OFS_IRQ_STAT) begin
               prdata_next = {28'h0000000, irq_flags};
               stat_rd = 1'b1;
            end else if (PADDR == atcfg_pkg::OFS_IRQ_MASK) begin
               prdata_next = {28'h0000000, mask_reg};
            end else if (PADDR == atcfg_pkg::OFS_NAME_LEN) begin
               prdata_next = {27'h0000000, name_len_reg};
            end else if (PADDR != atcfg_pkg::OFS_CFG) begin
               pslverr_next = 1'b1;
            end
         end
      end
   end

   // ======================================================
   // interpreter
   logic [7:0] setting_reg [atcfg_pkg::SETTING_COUNT];
   logic auth_reg, auth_next;
   logic encr_reg, encr_next;
   logic dfu_reg, dfu_next;
   logic busy_reg, busy_next;
   logic [5:0] dump_idx_reg, dump_idx_next;
   logic wr_en;
   logic [5:0] wr_idx;
   logic [7:0] wr_val;
   logic err_ev, rsp_ev;
   atcfg_pkg::atcfg_link_type link;
   logic allowed;
   logic [5:0] arg_idx;
   logic resp_on;

   assign link = atcfg_pkg::atcfg_link_type'(link_s2_reg);
   assign arg_idx = arg_reg[atcfg_pkg::ARG_IDX_LSB +: atcfg_pkg::SETTING_AW];
   assign resp_on = setting_reg[atcfg_pkg::IDX_RESPONSE_ENABLE] != 8'h00;

   always_comb begin
      allowed = 1'b0;
      case (atcfg_pkg::atcfg_cmd_type'(cmd_code))
         atcfg_pkg::CMD_ATTENTION, atcfg_pkg::CMD_RESET, atcfg_pkg::CMD_FACTORY,
         atcfg_pkg::CMD_FIRMWARE_UPDATE: begin
            allowed = link != atcfg_pkg::LINK_CONNECT;
         end
         atcfg_pkg::CMD_PENDING_ABORT: begin
            allowed = link == atcfg_pkg::LINK_PENDING;
         end
         atcfg_pkg::CMD_ESCAPE, atcfg_pkg::CMD_RETURN_ONLINE, atcfg_pkg::CMD_SIGNAL_STRENGTH: begin
            allowed = link == atcfg_pkg::LINK_CONNECT;
         end
         default: begin
            allowed = link == atcfg_pkg::LINK_STANDBY;
         end
      endcase
   end

   always_comb begin
      auth_next = auth_reg;
      encr_next = encr_reg;
      dfu_next = dfu_reg;
      busy_next = busy_reg;
      dump_idx_next = dump_idx_reg;
      rsp_data_next = rsp_data_reg;
      rsp_kind_next = rsp_kind_reg;
      rsp_valid_next = rsp_valid_reg;
      name_len_next = name_len_reg;
      wr_en = 1'b0;
      wr_idx = arg_idx;
      wr_val = arg_reg[7:0];
      err_ev = 1'b0;
      rsp_ev = 1'b0;
      if (dfu_reg) begin
         rsp_kind_next = atcfg_pkg::RSP_GARBAGE;
         rsp_data_next = atcfg_pkg::GARBAGE_BYTE;
         rsp_valid_next = 1'b1;
      end else if (busy_reg) begin
         // dump walks one pair per cycle, then OK
         rsp_ev = 1'b1;
         if (dump_idx_reg == 6'(atcfg_pkg::SETTING_COUNT)) begin
            rsp_kind_next = atcfg_pkg::RSP_OK;
            busy_next = 1'b0;
         end else begin
            rsp_kind_next = atcfg_pkg::RSP_DUMP_PAIR;
            rsp_data_next = setting_reg[dump_idx_reg];
            dump_idx_next = dump_idx_reg + 6'h01;
         end
      end else if (cmd_go) begin
         rsp_ev = 1'b1;
         rsp_kind_next = atcfg_pkg::RSP_OK;
         rsp_data_next = 8'h00;
         if (!allowed) begin
            rsp_kind_next = atcfg_pkg::RSP_ERROR;
            err_ev = 1'b1;
         end else begin
            case (atcfg_pkg::atcfg_cmd_type'(cmd_code))
               atcfg_pkg::CMD_SECURITY_SET: begin
                  auth_next = arg_reg[atcfg_pkg::ARG_AUTH_BIT];
                  encr_next = arg_reg[atcfg_pkg::ARG_ENCR_BIT];
               end
               atcfg_pkg::CMD_NAME_SET: begin
                  if (arg_reg[7:0] > 8'(atcfg_pkg::NAME_MAX)) begin
                     rsp_kind_next = atcfg_pkg::RSP_ERROR;
                     err_ev = 1'b1;
                  end else begin
                     name_len_next = arg_reg[4:0];
                  end
               end
               atcfg_pkg::CMD_LOW_POWER_SET: begin
                  wr_en = 1'b1;
                  wr_idx = atcfg_pkg::IDX_LOW_POWER;
                  wr_val = {7'h00, arg_reg[0]};
               end
               atcfg_pkg::CMD_FIRMWARE_UPDATE: begin
                  dfu_next = 1'b1;
               end
               atcfg_pkg::CMD_SETTINGS_DUMP: begin
                  busy_next = 1'b1;
                  dump_idx_next = 6'h00;
                  rsp_ev = 1'b0;
                  rsp_kind_next = rsp_kind_reg;
               end
               atcfg_pkg::CMD_SETTING_READ: begin
                  if (arg_idx >= 6'(atcfg_pkg::SETTING_COUNT)) begin
                     rsp_kind_next = atcfg_pkg::RSP_ERROR;
                     err_ev = 1'b1;
                  end else begin
                     rsp_kind_next = atcfg_pkg::RSP_VALUE;
                     rsp_data_next = setting_reg[arg_idx];
                  end
               end
               atcfg_pkg::CMD_SETTING_WRITE: begin
                  if (arg_idx >= 6'(atcfg_pkg::SETTING_COUNT) || PROTECT_MASK[arg_idx]) begin
                     rsp_kind_next = atcfg_pkg::RSP_ERROR;
                     err_ev = 1'b1;
                  end else begin
                     wr_en = 1'b1;
                  end
               end
               default: begin
               end
            endcase
         end
      end
      if (rsp_ev) begin
         rsp_valid_next = resp_on;
      end
   end

   // ======================================================
   // low power and wake latency
   logic lpm_reg, lpm_next;
   logic [63:0] wake_cnt_reg, wake_cnt_next;
   always_comb begin
      lpm_next = lpm_reg;
      wake_cnt_next = wake_cnt_reg;
      if (setting_reg[atcfg_pkg::IDX_LOW_POWER][0] && !act_s2_reg && !lpm_reg) begin
         lpm_next = 1'b1;
      end else if (lpm_reg && (act_s2_reg || !setting_reg[atcfg_pkg::IDX_LOW_POWER][0])) begin
         // wake is slow on purpose; the host must hold data off until it ends
         if (wake_cnt_reg == 64'(WAKE_CYC - 1)) begin
            lpm_next = 1'b0;
            wake_cnt_next = 64'h0;
         end else begin
            wake_cnt_next = wake_cnt_reg + 64'h1;
         end
      end
   end

   assign status_word = {27'h0000000, busy_reg, lpm_reg, dfu_reg, encr_reg, auth_reg};

   // ======================================================
   // interrupt flags
   atcfg_sticky u_rsp_flag (
      .clk(REF_CLK), .srst(SRST), .set(rsp_ev), .clr(stat_rd), .q(irq_flags[atcfg_pkg::IRQ_RSP_BIT]));
   atcfg_sticky u_err_flag (
      .clk(REF_CLK), .srst(SRST), .set(err_ev), .clr(stat_rd), .q(irq_flags[atcfg_pkg::IRQ_ERR_BIT]));
   assign irq_flags[3:2] = 2'b00;
   logic irq_reg;

   // ======================================================
   // registers
   always_ff @(posedge REF_CLK) begin
      link_s1_reg <= LINK_STATUS;
      link_s2_reg <= link_s1_reg;
      act_s1_reg <= DATA_ACTIVE;
      act_s2_reg <= act_s1_reg;
      if (SRST) begin
         prdata_reg <= 32'h0000_0000;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         arg_reg <= 32'h0000_0000;
         mask_reg <= 4'h0;
         auth_reg <= 1'b0;
         encr_reg <= 1'b0;
         dfu_reg <= 1'b0;
         busy_reg <= 1'b0;
         dump_idx_reg <= 6'h00;
         rsp_data_reg <= 8'h00;
         rsp_kind_reg <= 3'h0;
         rsp_valid_reg <= 1'b0;
         name_len_reg <= 5'h00;
         lpm_reg <= 1'b0;
         wake_cnt_reg <= 64'h0;
         irq_reg <= 1'b0;
         // hardware reset is the only thing that clears settings
         for (int i = 0; i < atcfg_pkg::SETTING_COUNT; i++) begin
            setting_reg[i] <= 8'h00;
         end
         setting_reg[atcfg_pkg::IDX_RESPONSE_ENABLE] <= atcfg_pkg::RESPONSE_ENABLE_RESET;
         setting_reg[atcfg_pkg::IDX_LOW_POWER] <= atcfg_pkg::LOW_POWER_RESET;
      end else begin
         prdata_reg <= prdata_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
         arg_reg <= arg_next;
         mask_reg <= mask_next;
         auth_reg <= auth_next;
         encr_reg <= encr_next;
         dfu_reg <= dfu_next;
         busy_reg <= busy_next;
         dump_idx_reg <= dump_idx_next;
         rsp_data_reg <= rsp_data_next;
         rsp_kind_reg <= rsp_kind_next;
         rsp_valid_reg <= rsp_valid_next;
         name_len_reg <= name_len_next;
         lpm_reg <= lpm_next;
         wake_cnt_reg <= wake_cnt_next;
         irq_reg <= |(irq_flags & mask_reg);
         if (wr_en) begin
            setting_reg[wr_idx] <= wr_val;
         end
      end
   end

   assign PRDATA = prdata_reg;
   assign PREADY = pready_reg;
   assign PSLVERR = pslverr_reg;
   assign LOW_POWER = lpm_reg;
   assign IRQ = irq_reg;

   // ======================================================
   // checks
   AST_SEC_DEFAULT: assert property (@(posedge REF_CLK) $fell(SRST) |-> !auth_reg && !encr_reg)
      else $error("security flags not cleared");
   AST_SEC_STORE: assert property (@(posedge REF_CLK) disable iff (SRST)
      cmd_go && allowed && !busy_reg && !dfu_reg && cmd_code == 4'(atcfg_pkg::CMD_SECURITY_SET)
      |=> auth_reg == $past(arg_reg[atcfg_pkg::ARG_AUTH_BIT]))
      else $error("auth flag not stored");
   AST_NAME_LIMIT: assert property (@(posedge REF_CLK) disable iff (SRST)
      name_len_reg <= 5'(atcfg_pkg::NAME_MAX))
      else $error("name too long");
   AST_DFU_GARBAGE: assert property (@(posedge REF_CLK) disable iff (SRST)
      dfu_reg |=> rsp_kind_reg == 3'(atcfg_pkg::RSP_GARBAGE))
      else $error("dfu not emitting garbage");
   AST_WRITE_PROT: assert property (@(posedge REF_CLK) disable iff (SRST)
      cmd_go && !busy_reg && !dfu_reg && allowed && cmd_code == 4'(atcfg_pkg::CMD_SETTING_WRITE)
      && arg_idx < 6'(atcfg_pkg::SETTING_COUNT) && PROTECT_MASK[arg_idx]
      |=> rsp_kind_reg == 3'(atcfg_pkg::RSP_ERROR))
      else $error("protected write not refused");
   AST_ABORT_PEND: assert property (@(posedge REF_CLK) disable iff (SRST)
      cmd_go && !busy_reg && !dfu_reg && cmd_code == 4'(atcfg_pkg::CMD_PENDING_ABORT)
      && link != atcfg_pkg::LINK_PENDING |=> rsp_kind_reg == 3'(atcfg_pkg::RSP_ERROR))
      else $error("abort outside pending");
   AST_REJECT: assert property (@(posedge REF_CLK) disable iff (SRST)
      cmd_go && !allowed && !busy_reg && !dfu_reg |=> rsp_kind_reg == 3'(atcfg_pkg::RSP_ERROR)
      && rsp_valid_reg == $past(resp_on))
      else $error("invalid command not refused");
   AST_SILENT: assert property (@(posedge REF_CLK) disable iff (SRST)
      rsp_ev && !resp_on && !dfu_reg |=> !rsp_valid_reg)
      else $error("response not suppressed");
   AST_CONN_ONLY: assert property (@(posedge REF_CLK) disable iff (SRST)
      cmd_go && !busy_reg && !dfu_reg && cmd_code == 4'(atcfg_pkg::CMD_SIGNAL_STRENGTH)
      && link != atcfg_pkg::LINK_CONNECT |=> rsp_kind_reg == 3'(atcfg_pkg::RSP_ERROR))
      else $error("connected-only accepted offline");
   AST_UNCONN: assert property (@(posedge REF_CLK) disable iff (SRST)
      cmd_go && !busy_reg && !dfu_reg && cmd_code == 4'(atcfg_pkg::CMD_NAME_SET)
      && link != atcfg_pkg::LINK_STANDBY |=> rsp_kind_reg == 3'(atcfg_pkg::RSP_ERROR) && $stable(name_len_reg))
      else $error("unconnected-only accepted");
   COV_DUMP: cover property (@(posedge REF_CLK) busy_reg ##1 !busy_reg);
   COV_DFU: cover property (@(posedge REF_CLK) $rose(dfu_reg));
   COV_WAKE: cover property (@(posedge REF_CLK) $fell(lpm_reg));
   COV_IRQ: cover property (@(posedge REF_CLK) $rose(irq_reg));
endmodule

// *** testbench/atcfg_host_model.sv ***
`timescale 1ns/1ps
// ====================
// host side: apb master plus link status and data activity lines
module atcfg_host_model (
   input wire logic clk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   output logic [1:0] link_status,
   output logic data_active,
   output logic hung
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      link_status = 2'h0;
      data_active = 1'b0;
      hung = 1'b0;
   end
   // ====================
   // one transfer; request held until pready is sampled high or 64 cycles pass
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
                       output logic err);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 64);
      if (n >= 64) hung = 1'b1;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic cmd(input logic [3:0] code, input logic [31:0] arg);
      logic [31:0] rd;
      logic e;
      xfer(1'b1, atcfg_pkg::OFS_ARG, arg, rd, e);
      xfer(1'b1, atcfg_pkg::OFS_CMD, {28'h0, code}, rd, e);
   endtask
   // link is synchronised inside, so let it settle
   task automatic set_link(input logic [1:0] s);
      link_status <= s;
      repeat (4) @(posedge clk);
   endtask
   task automatic set_active(input logic v);
      data_active <= v;
      @(posedge clk);
   endtask
   task automatic sec(input logic auth, input logic encr);
      if (auth) cmd(4'h4, 32'h0);
      cmd(4'h3, {30'h0, encr & auth, auth});
   endtask
   task automatic set_write(input logic [5:0] idx, input logic [7:0] val);
      set_link(2'h0);
      cmd(4'hb, {18'h0, idx, val});
   endtask
endmodule

// *** testbench/tb_atcfg_interp.sv ***
`timescale 1ns/1ps
// ====================
// bench for the command interpreter
module tb_atcfg_interp;
   logic ref_clk = 1'b0;
   logic srst = 1'b1;
   logic psel, penable, pwrite, pready, pslverr, data_active, low_power, irq, hung, e;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [1:0] link_status;
   int n_mismatch = 0;
   int n_tests = 0;
   always #2.5 ref_clk = ~ref_clk;
   // short wake time keeps the run brief; bit 5 protected to reach the refusal path
   atcfg_interp #(.WAKE_CYC(10), .PROTECT_MASK(47'h0000_0000_0020)) u_dut (.REF_CLK(ref_clk), .SRST(srst),
      .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .LINK_STATUS(link_status), .DATA_ACTIVE(data_active),
      .LOW_POWER(low_power), .IRQ(irq));
   atcfg_host_model u_host (.clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link_status(link_status),
      .data_active(data_active), .hung(hung));
   // ====================
   // helpers
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic rd_reg(input logic [7:0] a);
      u_host.xfer(1'b0, a, 32'h0, rd, e);
   endtask
   task automatic rsp_chk(input logic [2:0] kind, input string what);
      rd_reg(atcfg_pkg::OFS_RSP);
      chk(32'(rd[11:8]), 32'({1'b1, kind}), what);
   endtask
   task automatic wait_lp(input logic v);
      int n;
      n = 0;
      while (low_power !== v && n < 40) begin
         @(posedge ref_clk);
         n++;
      end
      chk({31'h0, low_power}, {31'h0, v}, "low power level");
      if (low_power !== v) finish_test();
   endtask
   function automatic logic ok_in(input logic [3:0] c, input logic [1:0] s);
      case (c)
         4'h0, 4'h1, 4'h2, 4'h8: ok_in = (s != 2'h2);
         4'hc: ok_in = (s == 2'h1);
         4'hd, 4'he, 4'hf: ok_in = (s == 2'h2);
         default: ok_in = (s == 2'h0);
      endcase
   endfunction
   task automatic finish_test;
      if (hung === 1'b1) n_mismatch++;
      if (n_mismatch == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // ====================
   // scenarios
   task automatic t_reset;
      rd_reg(atcfg_pkg::OFS_STATUS);
      chk(rd, 32'h0, "status after reset");
      chk({30'h0, low_power, irq}, 32'h0, "outputs after reset");
      rd_reg(atcfg_pkg::OFS_CFG);
      chk(rd, 32'h0, "reserved word");
      u_host.xfer(1'b0, 8'h20, 32'h0, rd, e);
      chk({31'h0, e}, 32'h1, "unmapped slverr");
      u_host.cmd(4'ha, 32'h0000_0a00);
      rd_reg(atcfg_pkg::OFS_RSP);
      chk(32'(rd[11:0]), 32'({1'b1, atcfg_pkg::RSP_VALUE, atcfg_pkg::RESPONSE_ENABLE_RESET}), "read value");
   endtask
   task automatic t_security;
      logic [1:0] combos [3] = '{2'b00, 2'b01, 2'b11};
      for (int i = 0; i < 3; i++) begin
         u_host.sec(combos[i][0], combos[i][1]);
         rsp_chk(atcfg_pkg::RSP_OK, "security answer");
         rd_reg(atcfg_pkg::OFS_STATUS);
         chk(32'(rd[1:0]), 32'(combos[i]), "security flags");
      end
   endtask
   task automatic t_name;
      u_host.cmd(4'h5, 32'(atcfg_pkg::NAME_MAX));
      rsp_chk(atcfg_pkg::RSP_OK, "name at limit");
      rd_reg(atcfg_pkg::OFS_NAME_LEN);
      chk(rd, 32'd30, "name length");
      u_host.cmd(4'h5, 32'd31);
      rsp_chk(atcfg_pkg::RSP_ERROR, "name too long");
   endtask
   task automatic t_validity;
      for (int s = 0; s < 3; s++) begin
         u_host.set_link(2'(s));
         for (int c = 0; c < 16; c++) begin
            // firmware update and dump run separately; writes only from standby
            if (c == 8 || c == 9 || (c == 11 && s != 0)) continue;
            u_host.cmd(4'(c), 32'h0);
            rd_reg(atcfg_pkg::OFS_RSP);
            if (ok_in(4'(c), 2'(s))) chk(32'(rd[11] === 1'b1 && rd[10:8] !== atcfg_pkg::RSP_ERROR), 32'h1,
               "accepted command");
            else chk(32'(rd[11:8]), 32'ha, "refused command");
         end
      end
      u_host.set_link(2'h0);
   endtask
   task automatic t_low_power;
      u_host.cmd(4'h6, 32'h1);
      rsp_chk(atcfg_pkg::RSP_OK, "low power on");
      wait_lp(1'b1);
      u_host.set_active(1'b1);
      repeat (5) @(posedge ref_clk);
      chk({31'h0, low_power}, 32'h1, "wake latency");
      wait_lp(1'b0);
      // disable while busy so the idle line cannot put it back to sleep
      u_host.cmd(4'h6, 32'h0);
      u_host.set_active(1'b0);
      rd_reg(atcfg_pkg::OFS_STATUS);
      chk(32'(rd[atcfg_pkg::ST_LPM_BIT]), 32'h0, "low power off");
   endtask
   task automatic t_settings;
      u_host.set_write(6'h05, 8'h33);
      rsp_chk(atcfg_pkg::RSP_ERROR, "protected write");
      u_host.set_write(atcfg_pkg::IDX_LOW_POWER, 8'h00);
      rsp_chk(atcfg_pkg::RSP_OK, "plain write");
      u_host.set_write(atcfg_pkg::IDX_RESPONSE_ENABLE, 8'h00);
      u_host.cmd(4'h1, 32'h0);
      u_host.cmd(4'h0, 32'h0);
      rd_reg(atcfg_pkg::OFS_RSP);
      chk(32'(rd[11]), 32'h0, "responses suppressed after reset command");
      u_host.set_write(atcfg_pkg::IDX_RESPONSE_ENABLE, 8'h01);
      u_host.cmd(4'h0, 32'h0);
      rsp_chk(atcfg_pkg::RSP_OK, "responses back");
   endtask
   task automatic t_irq;
      u_host.xfer(1'b1, atcfg_pkg::OFS_IRQ_MASK, 32'h0, rd, e);
      rd_reg(atcfg_pkg::OFS_IRQ_STAT);
      u_host.cmd(4'h0, 32'h0);
      repeat (3) @(posedge ref_clk);
      chk({31'h0, irq}, 32'h0, "masked irq");
      rd_reg(atcfg_pkg::OFS_IRQ_STAT);
      chk(32'(rd[atcfg_pkg::IRQ_RSP_BIT]), 32'h1, "sticky event");
      u_host.xfer(1'b1, atcfg_pkg::OFS_IRQ_MASK, 32'h1, rd, e);
      u_host.cmd(4'h0, 32'h0);
      repeat (3) @(posedge ref_clk);
      chk({31'h0, irq}, 32'h1, "unmasked irq");
      rd_reg(atcfg_pkg::OFS_IRQ_STAT);
      repeat (3) @(posedge ref_clk);
      chk({31'h0, irq}, 32'h0, "irq cleared by read");
   endtask
   task automatic t_dump;
      int n;
      n = 0;
      u_host.cmd(4'h9, 32'h0);
      rsp_chk(atcfg_pkg::RSP_DUMP_PAIR, "dump pair");
      rd_reg(atcfg_pkg::OFS_STATUS);
      chk(32'(rd[atcfg_pkg::ST_BUSY_BIT]), 32'h1, "dump running");
      while (rd[atcfg_pkg::ST_BUSY_BIT] !== 1'b0 && n < 20) begin
         rd_reg(atcfg_pkg::OFS_STATUS);
         n++;
      end
      chk(32'(rd[atcfg_pkg::ST_BUSY_BIT]), 32'h0, "dump ends");
      if (rd[atcfg_pkg::ST_BUSY_BIT] !== 1'b0) finish_test();
      rsp_chk(atcfg_pkg::RSP_OK, "dump closing ok");
   endtask
   task automatic t_firmware;
      u_host.cmd(4'h8, 32'h0);
      rd_reg(atcfg_pkg::OFS_RSP);
      chk(32'(rd[10:0]), 32'({atcfg_pkg::RSP_GARBAGE, atcfg_pkg::GARBAGE_BYTE}), "garbage output");
      rd_reg(atcfg_pkg::OFS_STATUS);
      chk(32'(rd[atcfg_pkg::ST_DFU_BIT]), 32'h1, "update mode");
      u_host.cmd(4'h0, 32'h0);
      rd_reg(atcfg_pkg::OFS_RSP);
      chk(32'(rd[10:8]), 32'(atcfg_pkg::RSP_GARBAGE), "no normal answer");
   endtask
   // ====================
   // main sequence and watchdog
   initial begin
      repeat (10) @(posedge ref_clk);
      srst <= 1'b0;
      t_reset();
      t_security();
      t_name();
      t_validity();
      t_low_power();
      t_settings();
      t_irq();
      t_dump();
      t_firmware();
      finish_test();
   end
   // a stuck bus transfer ends the run at once
   initial begin
      int i;
      i = 0;
      while (i < 100000 && hung !== 1'b1) begin
         @(posedge ref_clk);
         i++;
      end
      n_mismatch++;
      finish_test();
   end
endmodule
